// ---- core/sfic_pkg.sv ----
// shared constants for the supply fault input conditioning block
package sfic_pkg;
	localparam int NUM_DED       = 5;
	localparam int NUM_DUAL      = 5;
	localparam int NUM_IN        = 10;
	localparam int CODE_W        = 8;
	localparam int HYST_W        = 5;
	localparam int TIME_W        = 7;
	localparam int CLK_MHZ       = 40;
	localparam int US_CYCLES     = CLK_MHZ;
	localparam int MAX_TIME_US   = 100;
	localparam int HV_INDEX      = 4;
	// range selections; a 2-bit code per analog detector
	localparam logic [1:0] RANGE_LOW  = 2'h0;
	localparam logic [1:0] RANGE_MID  = 2'h1;
	localparam logic [1:0] RANGE_HIGH = 2'h2;
	localparam logic [1:0] RANGE_HV   = 2'h3;
	// range bottoms and spans in millivolts
	localparam int BOTTOM_LOW_MV  = 573;
	localparam int SPAN_LOW_MV    = 802;
	localparam int BOTTOM_MID_MV  = 1250;
	localparam int SPAN_MID_MV    = 1750;
	localparam int BOTTOM_HIGH_MV = 2500;
	localparam int SPAN_HIGH_MV   = 3500;
	localparam int BOTTOM_HV_MV   = 6000;
	localparam int SPAN_HV_MV     = 9600;
	localparam int CODE_FULL      = 255;
	// fault type per detector
	typedef enum logic [1:0] {
		SFIC_FAULT_LOWER  = 2'h0,
		SFIC_FAULT_UPPER  = 2'h1,
		SFIC_FAULT_WINDOW = 2'h3
	} sfic_fault_t;
	localparam int FILT_CNT_W = 13;
endpackage

// ---- core/sfic_glitch_filter.sv ----
// programmable glitch filter: passes a level only after it held for the timeout
`timescale 1ns/1ps
`default_nettype none
module sfic_glitch_filter #(
	parameter int TIME_W = sfic_pkg::TIME_W
) (
	input  wire logic              clock,     // 40 MHz clock
	input  wire logic              sys_rst,   // synchronous reset, high
	input  wire logic              us_tick,   // one-cycle pulse each microsecond
	input  wire logic [TIME_W-1:0] timeout,   // timeout in microseconds, 0 = none
	input  wire logic              raw,       // synchronised comparator level
	output logic                   filtered   // filtered level
);
	logic [TIME_W-1:0] held_us;
	logic              pending;
	wire               differs = raw != filtered;
	// the first tick after a change ends a partial microsecond, so a level
	// passes only after the timeout in whole microseconds: shorter pulses never pass
	wire               expired = (held_us > timeout);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			filtered <= 1'b0;
			held_us  <= '0;
			pending  <= 1'b0;
		end else if (!differs) begin
			held_us <= '0;
			pending <= 1'b0;
		end else if (timeout == '0 || (pending && expired)) begin
			filtered <= raw; // R9
			held_us  <= '0;
			pending  <= 1'b0;
		end else begin
			// a short pulse returns to filtered level and resets the count
			pending <= 1'b1; // R8
			if (us_tick && !expired)
				held_us <= held_us + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- core/sfic_core.sv ----
// ten-input supply fault detection and logic input conditioning
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: ten inputs: five dedicated detectors, five dual-function, analog or logic exclusively.
// R2: each detector flags lower-limit, upper-limit or out-of-window faults.
// R3: thresholds are 8-bit codes; voltage is span times code over 255 plus bottom.
// R4: four ranges with documented bottoms and spans.
// R5: high-voltage input two upper ranges, positive three lower, dual lowest only.
// R6: hysteresis is a 5-bit code up to 31, span times code over 255.
// R7: hysteresis only once faulted; fault clears past threshold by hysteresis.
// R8: glitch filter on each detector output suppresses pulses shorter than timeout.
// R9: longer pulses pass, delayed by exactly the programmed timeout; the code delays them by the timeout to the timeout plus one microsecond.
// R10: logic-mode dual inputs move their detector to a dedicated input as secondary.
// R11: secondary detector shares primary range; its output is a warning.
// R12: warnings readable as status and ORed into one warning to the core.
// R13: logic inputs select level or edge detection.
// R14: level mode outputs the filtered level.
// R15: edge mode emits one pulse of programmable width, 0 to 100 us.
// R16: logic inputs use the same glitch filter.
// R17: logic inputs have selectable weak pull-down enable.
// R18: conditioned logic inputs go to the state machine core.
// R19: filtered detector outputs are the core's pin status.
// R20: asynchronous inputs pass two flip-flops before filtering or edge detection.
// R21: durations count a microsecond timebase; zero means no delay.
module sfic_core #(
	parameter int NUM_DED  = sfic_pkg::NUM_DED,
	parameter int NUM_DUAL = sfic_pkg::NUM_DUAL,
	parameter int CODE_W   = sfic_pkg::CODE_W,
	parameter int HYST_W   = sfic_pkg::HYST_W,
	parameter int TIME_W   = sfic_pkg::TIME_W
) (
	input  wire logic                       clock,             // 40 MHz clock
	input  wire logic                       sys_rst,           // synchronous reset
	// analog input levels in millivolts (from front-end converter)
	input  wire logic [NUM_DED*16-1:0]      ded_level_mv,      // dedicated input levels
	input  wire logic [NUM_DUAL*16-1:0]     dual_level_mv,     // dual input levels
	input  wire logic [NUM_DUAL-1:0]        dual_pin,          // dual inputs as logic pins
	// configuration of the dedicated detectors
	input  wire logic [NUM_DED*2-1:0]       ded_range,         // range selection
	input  wire logic [NUM_DED*2-1:0]       ded_fault_type,    // fault type
	input  wire logic [NUM_DED*CODE_W-1:0]  ded_lower_code,    // lower limit codes
	input  wire logic [NUM_DED*CODE_W-1:0]  ded_upper_code,    // upper limit codes
	input  wire logic [NUM_DED*HYST_W-1:0]  ded_hyst_code,     // hysteresis codes
	input  wire logic [NUM_DED*TIME_W-1:0]  ded_filter_us,     // glitch timeouts
	// configuration of the dual-function inputs
	input  wire logic [NUM_DUAL-1:0]        dual_logic_mode,   // 1 = logic input
	input  wire logic [NUM_DUAL-1:0]        dual_edge_mode,    // 1 = edge detection
	input  wire logic [NUM_DUAL-1:0]        dual_pulldown_sel, // weak pull-down select
	input  wire logic [NUM_DUAL*2-1:0]      dual_fault_type,   // fault type
	input  wire logic [NUM_DUAL*CODE_W-1:0] dual_lower_code,   // lower limit codes
	input  wire logic [NUM_DUAL*CODE_W-1:0] dual_upper_code,   // upper limit codes
	input  wire logic [NUM_DUAL*HYST_W-1:0] dual_hyst_code,    // hysteresis codes
	input  wire logic [NUM_DUAL*TIME_W-1:0] dual_filter_us,    // glitch timeouts
	input  wire logic [NUM_DUAL*TIME_W-1:0] dual_pulse_us,     // edge pulse widths
	// results
	output logic      [NUM_DED-1:0]         ded_fault,         // filtered dedicated faults
	output logic      [NUM_DUAL-1:0]        dual_fault,        // filtered dual faults
	output logic      [NUM_DUAL-1:0]        warning_status,    // per-input warnings
	output logic                            warning_any,       // ORed warning to core
	output logic      [NUM_DUAL-1:0]        logic_out,         // conditioned logic inputs
	output logic      [NUM_DUAL-1:0]        pulldown_en,       // weak pull-down enables
	output logic      [NUM_DED*2-1:0]       ded_range_used     // range actually applied
);
	localparam int NUM_IN = NUM_DED + NUM_DUAL;
	localparam int MV_W   = 16;
	localparam int PROD_W = 32;

	// microsecond timebase
	localparam logic [5:0] US_LAST = 6'(sfic_pkg::US_CYCLES - 1);
	logic [5:0] us_div;
	wire        us_tick = (us_div == US_LAST); // R21
	always_ff @(posedge clock) begin
		if (sys_rst)
			us_div <= '0;
		else
			us_div <= us_tick ? '0 : us_div + 6'h01;
	end

	// timeouts clipped to the documented maximum
	localparam logic [TIME_W-1:0] MAX_US = TIME_W'(sfic_pkg::MAX_TIME_US);
	function automatic logic [TIME_W-1:0] clip_us(input logic [TIME_W-1:0] t);
		clip_us = (t > MAX_US) ? MAX_US : t;
	endfunction

	function automatic logic [MV_W-1:0] bottom_mv(input logic [1:0] r);
		case (r)
			sfic_pkg::RANGE_LOW:  bottom_mv = MV_W'(sfic_pkg::BOTTOM_LOW_MV);
			sfic_pkg::RANGE_MID:  bottom_mv = MV_W'(sfic_pkg::BOTTOM_MID_MV);
			sfic_pkg::RANGE_HIGH: bottom_mv = MV_W'(sfic_pkg::BOTTOM_HIGH_MV);
			default:              bottom_mv = MV_W'(sfic_pkg::BOTTOM_HV_MV);
		endcase
	endfunction

	function automatic logic [MV_W-1:0] span_mv(input logic [1:0] r);
		case (r)
			sfic_pkg::RANGE_LOW:  span_mv = MV_W'(sfic_pkg::SPAN_LOW_MV);
			sfic_pkg::RANGE_MID:  span_mv = MV_W'(sfic_pkg::SPAN_MID_MV);
			sfic_pkg::RANGE_HIGH: span_mv = MV_W'(sfic_pkg::SPAN_HIGH_MV);
			default:              span_mv = MV_W'(sfic_pkg::SPAN_HV_MV);
		endcase
	endfunction

	// span * code / 255 in millivolts
	function automatic logic [MV_W-1:0] scale_mv(input logic [MV_W-1:0] span,
	                                             input logic [CODE_W-1:0] code);
		logic [PROD_W-1:0] prod;
		prod = PROD_W'(span) * PROD_W'(code);
		scale_mv = MV_W'(prod / PROD_W'(sfic_pkg::CODE_FULL));
	endfunction

	// legal range per dedicated input; positive inputs lack the top range
	function automatic logic [1:0] legal_range(input int idx, input logic [1:0] r);
		if (idx == sfic_pkg::HV_INDEX)
			legal_range = (r == sfic_pkg::RANGE_HV) ? sfic_pkg::RANGE_HV
			                                        : sfic_pkg::RANGE_HIGH;
		else
			legal_range = (r == sfic_pkg::RANGE_HV) ? sfic_pkg::RANGE_HIGH : r;
	endfunction

	// two-flop synchroniser for logic pins
	logic [NUM_DUAL-1:0] pin_meta;
	logic [NUM_DUAL-1:0] pin_sync;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= dual_pin; // R20
			pin_sync <= pin_meta;
		end
	end

	// per-detector arrays: index 0..4 dedicated, 5..9 dual-function
	logic [MV_W-1:0]   det_level  [NUM_IN];
	logic [1:0]        det_range  [NUM_IN];
	logic [1:0]        det_type   [NUM_IN];
	logic [CODE_W-1:0] det_lo     [NUM_IN];
	logic [CODE_W-1:0] det_hi     [NUM_IN];
	logic [HYST_W-1:0] det_hyst   [NUM_IN];
	logic [TIME_W-1:0] det_filt   [NUM_IN];
	logic [NUM_IN-1:0] lo_fault;
	logic [NUM_IN-1:0] hi_fault;
	logic [NUM_IN-1:0] comp_meta;
	logic [NUM_IN-1:0] comp_sync;
	logic [NUM_IN-1:0] filt_out;

	genvar g;
	generate
		for (g = 0; g < NUM_IN; g++) begin : g_det
			if (g < NUM_DED) begin : g_ded
				assign det_level[g] = ded_level_mv[g*MV_W +: MV_W];
				assign det_range[g] = legal_range(g, ded_range[g*2 +: 2]); // R5
				assign det_type[g]  = ded_fault_type[g*2 +: 2];
				assign det_lo[g]    = ded_lower_code[g*CODE_W +: CODE_W];
				assign det_hi[g]    = ded_upper_code[g*CODE_W +: CODE_W];
				assign det_hyst[g]  = ded_hyst_code[g*HYST_W +: HYST_W];
				assign det_filt[g]  = clip_us(ded_filter_us[g*TIME_W +: TIME_W]);
				assign ded_range_used[g*2 +: 2] = det_range[g];
			end else begin : g_dual
				localparam int K = g - NUM_DED;
				wire secondary = dual_logic_mode[K]; // R1
				// secondary watches its dedicated partner with partner's range
				assign det_level[g] = secondary ? det_level[K]
				                                : dual_level_mv[K*MV_W +: MV_W]; // R10
				assign det_range[g] = secondary ? det_range[K]
				                                : sfic_pkg::RANGE_LOW; // R11
				assign det_type[g]  = dual_fault_type[K*2 +: 2];
				assign det_lo[g]    = dual_lower_code[K*CODE_W +: CODE_W];
				assign det_hi[g]    = dual_upper_code[K*CODE_W +: CODE_W];
				assign det_hyst[g]  = dual_hyst_code[K*HYST_W +: HYST_W];
				assign det_filt[g]  = clip_us(dual_filter_us[K*TIME_W +: TIME_W]);
			end

			// threshold voltages
			wire [MV_W-1:0] span    = span_mv(det_range[g]);
			wire [MV_W-1:0] bottom  = bottom_mv(det_range[g]);
			wire [MV_W-1:0] lo_th   = MV_W'(scale_mv(span, det_lo[g]) + bottom); // R3
			wire [MV_W-1:0] hi_th   = MV_W'(scale_mv(span, det_hi[g]) + bottom); // R4
			wire [MV_W-1:0] hyst_mv = scale_mv(span, CODE_W'(det_hyst[g])); // R6
			wire            use_lo  = det_type[g] != sfic_pkg::SFIC_FAULT_UPPER;
			wire            use_hi  = det_type[g] != sfic_pkg::SFIC_FAULT_LOWER;
			wire [MV_W:0]   lo_rel  = {1'b0, lo_th} + {1'b0, hyst_mv};
			wire [MV_W:0]   hi_rel  = {1'b0, hi_th} - {1'b0, hyst_mv};
			// hysteresis moves the compare point only while faulted
			wire next_lo = use_lo && (lo_fault[g]
			               ? ({1'b0, det_level[g]} <= lo_rel)
			               : (det_level[g] < lo_th)); // R7
			wire next_hi = use_hi && (hi_fault[g]
			               ? (hi_rel[MV_W] || {1'b0, det_level[g]} >= hi_rel)
			               : (det_level[g] > hi_th)); // R7

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					lo_fault[g] <= 1'b0;
					hi_fault[g] <= 1'b0;
				end else begin
					lo_fault[g] <= next_lo; // R2
					hi_fault[g] <= next_hi;
				end
			end

			// comparator result treated as asynchronous to the filter
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					comp_meta[g] <= 1'b0;
					comp_sync[g] <= 1'b0;
				end else begin
					comp_meta[g] <= lo_fault[g] | hi_fault[g]; // R20
					comp_sync[g] <= comp_meta[g];
				end
			end

			wire filt_in;
			if (g < NUM_DED) begin : g_in_ded
				assign filt_in = comp_sync[g];
			end else begin : g_in_dual
				// logic mode filters the pin, else the analog comparator
				assign filt_in = dual_logic_mode[g-NUM_DED] ? pin_sync[g-NUM_DED]
				                                            : comp_sync[g]; // R16
			end

			sfic_glitch_filter #(
				.TIME_W (TIME_W)
			) u_filt (
				.clock    (clock),
				.sys_rst  (sys_rst),
				.us_tick  (us_tick),
				.timeout  (det_filt[g]),
				.raw      (filt_in),
				.filtered (filt_out[g])
			); // R8
		end
	endgenerate

	// secondary detector comparators keep running; route result by mode
	logic [NUM_DUAL-1:0] sec_cmp_meta;
	logic [NUM_DUAL-1:0] sec_cmp_sync;
	logic [NUM_DUAL-1:0] sec_filt;
	logic [NUM_DUAL-1:0] logic_prev;
	logic [TIME_W-1:0]   pulse_left [NUM_DUAL];
	logic [NUM_DUAL-1:0] pulse_on;

	generate
		for (g = 0; g < NUM_DUAL; g++) begin : g_dual_out
			wire [TIME_W-1:0] width = clip_us(dual_pulse_us[g*TIME_W +: TIME_W]);
			wire              lvl   = filt_out[NUM_DED+g];
			wire              edge_seen = (lvl != logic_prev[g]);
			wire              pulse_done = (pulse_left[g] == '0);

			// secondary is a separate filtered path on the same comparator
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					sec_cmp_meta[g] <= 1'b0;
					sec_cmp_sync[g] <= 1'b0;
				end else begin
					sec_cmp_meta[g] <= lo_fault[NUM_DED+g] | hi_fault[NUM_DED+g];
					sec_cmp_sync[g] <= sec_cmp_meta[g];
				end
			end

			sfic_glitch_filter #(
				.TIME_W (TIME_W)
			) u_sec_filt (
				.clock    (clock),
				.sys_rst  (sys_rst),
				.us_tick  (us_tick),
				.timeout  (det_filt[NUM_DED+g]),
				.raw      (sec_cmp_sync[g]),
				.filtered (sec_filt[g])
			);

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					logic_prev[g] <= 1'b0;
					pulse_left[g] <= '0;
					pulse_on[g]   <= 1'b0;
				end else begin
					logic_prev[g] <= lvl;
					if (edge_seen && width != '0) begin
						pulse_on[g]   <= 1'b1; // R15
						pulse_left[g] <= width;
					end else if (pulse_on[g] && us_tick) begin
						pulse_left[g] <= pulse_left[g] - 1'b1; // R21
						if (pulse_left[g] == TIME_W'(1))
							pulse_on[g] <= 1'b0;
					end else if (pulse_done) begin
						pulse_on[g] <= 1'b0;
					end
				end
			end

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					dual_fault[g]     <= 1'b0;
					warning_status[g] <= 1'b0;
					logic_out[g]      <= 1'b0;
					pulldown_en[g]    <= 1'b0;
				end else begin
					dual_fault[g]     <= !dual_logic_mode[g] && lvl; // R19
					warning_status[g] <= dual_logic_mode[g] && sec_filt[g]; // R12
					pulldown_en[g]    <= dual_logic_mode[g] && dual_pulldown_sel[g]; // R17
					if (!dual_logic_mode[g])
						logic_out[g] <= 1'b0;
					else if (dual_edge_mode[g]) // R13
						logic_out[g] <= pulse_on[g] || (edge_seen && width != '0);
					else
						logic_out[g] <= lvl; // R14
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ded_fault   <= '0;
			warning_any <= 1'b0;
		end else begin
			ded_fault   <= filt_out[NUM_DED-1:0]; // R19
			warning_any <= |warning_status; // R12
		end
	end
	// logic_out feeds the state machine core directly R18
endmodule
`default_nettype wire

// ---- verif/sfic_core_monitor.sv ----
// assertion checker for the supply fault input conditioning core
`timescale 1ns/1ps
`default_nettype none
module sfic_core_monitor #(
	parameter int NUM_DED  = 5,
	parameter int NUM_DUAL = 5,
	parameter int TIME_W   = 7
) (
	input wire logic                       clock,             // clock
	input wire logic                       sys_rst,           // reset
	input wire logic [NUM_DUAL-1:0]        dual_pin,          // logic pins
	input wire logic [NUM_DED*2-1:0]       ded_range,         // range request
	input wire logic [NUM_DUAL-1:0]        dual_logic_mode,   // logic mode
	input wire logic [NUM_DUAL-1:0]        dual_edge_mode,    // edge mode
	input wire logic [NUM_DUAL-1:0]        dual_pulldown_sel, // pull-down request
	input wire logic [NUM_DUAL*TIME_W-1:0] dual_filter_us,    // dual timeouts
	input wire logic [NUM_DED-1:0]         ded_fault,         // dedicated faults
	input wire logic [NUM_DUAL-1:0]        dual_fault,        // dual faults
	input wire logic [NUM_DUAL-1:0]        warning_status,    // warnings
	input wire logic                       warning_any,       // ored warning
	input wire logic [NUM_DUAL-1:0]        logic_out,         // logic outputs
	input wire logic [NUM_DUAL-1:0]        pulldown_en,       // pull-down enables
	input wire logic [NUM_DED*2-1:0]       ded_range_used     // applied range
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	reset_clear_a: assert property (
		disable iff (1'b0) sys_rst |=> (ded_fault == '0 && logic_out == '0 && !warning_any))
		else $error("outputs not cleared by reset");
	warn_or_a: assert property (!$past(sys_rst) |-> warning_any == |$past(warning_status))
		else $error("warning summary wrong");
	pulldown_a: assert property (
		!$past(sys_rst) |-> pulldown_en == $past(dual_logic_mode & dual_pulldown_sel))
		else $error("pull-down enable wrong");
	range_pos_a: assert property (
		ded_range_used[1:0] == ((ded_range[1:0] == 2'h3) ? 2'h2 : ded_range[1:0]))
		else $error("positive input range wrong");
	range_hv_a: assert property (
		ded_range_used[9:8] == (ded_range[9] ? ded_range[9:8] : 2'h2))
		else $error("high-voltage range wrong");
	analog_quiet_a: assert property (
		(!dual_logic_mode[1]) [*8] |-> !logic_out[1] && !warning_status[1])
		else $error("analog input shows logic or warning");
	logic_quiet_a: assert property (dual_logic_mode[0] [*8] |-> !dual_fault[0])
		else $error("logic input shows analog fault");
	level_follow_a: assert property (
		(dual_logic_mode[0] && !dual_edge_mode[0] && dual_filter_us[TIME_W-1:0] == '0) [*6]
		|-> logic_out[0] == $past(dual_pin[0], 4))
		else $error("level output does not follow pin");
	cover property ($rose(ded_fault[2]));
	cover property ($rose(warning_any));
	cover property (dual_edge_mode[3] && $rose(logic_out[3]));
endmodule
bind sfic_core sfic_core_monitor #(.NUM_DED(NUM_DED), .NUM_DUAL(NUM_DUAL), .TIME_W(TIME_W)) mon (
	.clock(clock), .sys_rst(sys_rst), .dual_pin(dual_pin), .ded_range(ded_range),
	.dual_logic_mode(dual_logic_mode), .dual_edge_mode(dual_edge_mode),
	.dual_pulldown_sel(dual_pulldown_sel), .dual_filter_us(dual_filter_us),
	.ded_fault(ded_fault), .dual_fault(dual_fault), .warning_status(warning_status),
	.warning_any(warning_any), .logic_out(logic_out), .pulldown_en(pulldown_en),
	.ded_range_used(ded_range_used));
`default_nettype wire

// ---- verif/sfic_rail_model.sv ----
// behavioural model of the monitored rails and the external logic pins
`timescale 1ns/1ps
`default_nettype none
module sfic_rail_model (
	input  wire logic        clock,         // clock
	input  wire logic [4:0]  pulldown_en,   // pull-down enables
	output logic      [79:0] ded_level_mv,  // dedicated rails
	output logic      [79:0] dual_level_mv, // dual rails
	output logic      [4:0]  dual_pin       // logic pins
);
	logic [4:0] drive;
	logic [4:0] floating;
	logic       flip;
	initial begin
		ded_level_mv = {16'h1B58, {4{16'h0BB8}}};
		dual_level_mv = {5{16'h03E8}};
		drive = 5'h00;
		floating = 5'h00;
		flip = 1'b0;
	end
	always @(posedge clock) flip <= ~flip;
	// an open pin without pull-down wanders every cycle
	assign dual_pin = (drive & ~floating) | (floating & ~pulldown_en & {5{flip}});
	task automatic set_ded(input int k, input logic [15:0] mv);
		@(posedge clock);
		ded_level_mv[k*16 +: 16] <= mv;
	endtask
	task automatic set_dual(input int k, input logic [15:0] mv);
		@(posedge clock);
		dual_level_mv[k*16 +: 16] <= mv;
	endtask
	task automatic set_pin(input int k, input logic v, input logic fl);
		@(posedge clock);
		drive[k] <= v;
		floating[k] <= fl;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking testbench of the supply fault input conditioning core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock, sys_rst, warning_any;
	logic [9:0]  ded_range, ded_fault_type, dual_fault_type, ded_range_used;
	logic [39:0] ded_lower_code, ded_upper_code, dual_lower_code, dual_upper_code;
	logic [24:0] ded_hyst_code, dual_hyst_code;
	logic [34:0] ded_filter_us, dual_filter_us, dual_pulse_us;
	logic [4:0]  dual_logic_mode, dual_edge_mode, dual_pulldown_sel, dual_pin;
	logic [4:0]  ded_fault, dual_fault, warning_status, logic_out, pulldown_en;
	logic [79:0] ded_level_mv, dual_level_mv;
	int          bad_count, compares;
	sfic_rail_model rails (.clock(clock), .pulldown_en(pulldown_en),
		.ded_level_mv(ded_level_mv), .dual_level_mv(dual_level_mv), .dual_pin(dual_pin));
	sfic_core dut (.clock(clock), .sys_rst(sys_rst), .ded_level_mv(ded_level_mv),
		.dual_level_mv(dual_level_mv), .dual_pin(dual_pin), .ded_range(ded_range),
		.ded_fault_type(ded_fault_type), .ded_lower_code(ded_lower_code),
		.ded_upper_code(ded_upper_code), .ded_hyst_code(ded_hyst_code),
		.ded_filter_us(ded_filter_us), .dual_logic_mode(dual_logic_mode),
		.dual_edge_mode(dual_edge_mode), .dual_pulldown_sel(dual_pulldown_sel),
		.dual_fault_type(dual_fault_type), .dual_lower_code(dual_lower_code),
		.dual_upper_code(dual_upper_code), .dual_hyst_code(dual_hyst_code),
		.dual_filter_us(dual_filter_us), .dual_pulse_us(dual_pulse_us),
		.ded_fault(ded_fault), .dual_fault(dual_fault), .warning_status(warning_status),
		.warning_any(warning_any), .logic_out(logic_out), .pulldown_en(pulldown_en),
		.ded_range_used(ded_range_used));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic count_high(input int k, output int n);
		n = 0;
		repeat (150) begin
			cyc(1);
			if (logic_out[k] === 1'b1) n++;
		end
	endtask
	task automatic t_lower;
		@(posedge clock);
		ded_lower_code[7:0] <= 8'h64;
		ded_hyst_code[4:0] <= 5'h0A;
		rails.set_ded(0, 16'h078F);
		cyc(4);
		chk("fault0 early", 16'h0, ded_fault[0]);
		cyc(3);
		chk("fault0", 16'h1, ded_fault[0]);
		rails.set_ded(0, 16'h07D4);
		cyc(10);
		chk("fault0 held", 16'h1, ded_fault[0]);
		rails.set_ded(0, 16'h07D5);
		cyc(10);
		chk("fault0 clear", 16'h0, ded_fault[0]);
	endtask
	task automatic t_upper;
		@(posedge clock);
		ded_range[3:2] <= 2'h2;
		ded_fault_type[3:2] <= 2'h1;
		ded_upper_code[15:8] <= 8'hB6;
		rails.set_ded(1, 16'h1386);
		cyc(10);
		chk("upper at limit", 16'h0, ded_fault[1]);
		rails.set_ded(1, 16'h1387);
		cyc(10);
		chk("upper over", 16'h1, ded_fault[1]);
		@(posedge clock);
		ded_fault_type[3:2] <= 2'h3;
		rails.set_ded(1, 16'h0BB8);
		cyc(10);
		chk("window inside", 16'h0, ded_fault[1]);
		rails.set_ded(1, 16'h09C3);
		cyc(10);
		chk("window below", 16'h1, ded_fault[1]);
	endtask
	task automatic t_ranges;
		@(posedge clock);
		ded_range <= {2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
		cyc(1);
		chk("hv range", 16'h2, ded_range_used[9:8]);
		chk("pos range", 16'h2, ded_range_used[1:0]);
		@(posedge clock);
		ded_range <= {2'h3, 2'h1, 2'h1, 2'h2, 2'h1};
		rails.set_ded(4, 16'h176F);
		cyc(10);
		chk("hv range", 16'h3, ded_range_used[9:8]);
		chk("hv bottom", 16'h1, ded_fault[4]);
	endtask
	task automatic t_glitch;
		int i;
		int hits;
		hits = 0;
		@(posedge clock);
		ded_filter_us[20:14] <= 7'h02;
		rails.set_ded(2, 16'h03E8);
		for (i = 0; i < 190; i++) begin
			if (i == 30) rails.set_ded(2, 16'h0BB8);
			cyc(1);
			if (ded_fault[2] !== 1'b0) hits++;
		end
		chk("glitch passed", 16'h0, hits[15:0]);
		rails.set_ded(2, 16'h03E8);
		for (i = 0; i < 200 && ded_fault[2] !== 1'b1; i++) cyc(1);
		chk("filter delay min", 16'h1, 16'(i >= 84));
		chk("filter delay max", 16'h1, 16'(i <= 126));
	endtask
	task automatic t_warning;
		@(posedge clock);
		dual_logic_mode[0] <= 1'b1;
		dual_lower_code[7:0] <= 8'h80;
		rails.set_ded(0, 16'h0834);
		cyc(12);
		chk("warning", 16'h1, warning_status[0]);
		chk("warning any", 16'h1, warning_any);
		chk("no fault", 16'h0, ded_fault[0]);
		rails.set_ded(0, 16'h0BB8);
		cyc(12);
		chk("warning any off", 16'h0, warning_any);
	endtask
	task automatic t_dual;
		rails.set_dual(1, 16'h0560);
		@(posedge clock);
		dual_lower_code[15:8] <= 8'hFF;
		cyc(10);
		chk("dual above", 16'h0, dual_fault[1]);
		rails.set_dual(1, 16'h055E);
		cyc(10);
		chk("dual below", 16'h1, dual_fault[1]);
	endtask
	task automatic t_logic;
		int n;
		rails.set_pin(0, 1'b1, 1'b0);
		cyc(6);
		chk("level high", 16'h1, logic_out[0]);
		rails.set_pin(0, 1'b0, 1'b0);
		cyc(6);
		chk("level low", 16'h0, logic_out[0]);
		@(posedge clock);
		dual_logic_mode[3] <= 1'b1;
		dual_edge_mode[3] <= 1'b1;
		dual_pulse_us[27:21] <= 7'h01;
		cyc(10);
		rails.set_pin(3, 1'b1, 1'b0);
		count_high(3, n);
		chk("rise pulse", 16'h1, 16'(n > 0 && n <= 80));
		rails.set_pin(3, 1'b0, 1'b0);
		count_high(3, n);
		chk("fall pulse", 16'h1, 16'(n > 0 && n <= 80));
		@(posedge clock);
		dual_pulse_us[27:21] <= 7'h00;
		rails.set_pin(3, 1'b1, 1'b0);
		count_high(3, n);
		chk("zero width", 16'h0, n[15:0]);
		@(posedge clock);
		dual_logic_mode[4] <= 1'b1;
		dual_pulldown_sel[4] <= 1'b1;
		rails.set_pin(4, 1'b1, 1'b1);
		count_high(4, n);
		chk("pulled low", 16'h0, n[15:0]);
		chk("pulldown on", 16'h1, pulldown_en[4]);
	endtask
	initial begin
		{ded_fault_type, dual_fault_type, ded_lower_code, ded_upper_code} = '0;
		{dual_lower_code, dual_upper_code, ded_hyst_code, dual_hyst_code} = '0;
		{ded_filter_us, dual_filter_us, dual_pulse_us} = '0;
		{dual_logic_mode, dual_edge_mode, dual_pulldown_sel} = '0;
		ded_range = 10'h355;
		sys_rst = 1'b1;
		bad_count = 0;
		compares = 0;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		cyc(5);
		t_lower();
		t_upper();
		t_ranges();
		t_glitch();
		t_warning();
		t_dual();
		t_logic();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
